// ===== src/byte_fifo.sv
// small valid/ready fifo carrying received link bytes to the command engine
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   // depth must be a power of two: pointers wrap by overflow
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;
   logic push;
   logic pop;

   assign in_ready_o = !((wr_ff[AW] != rd_ff[AW])
                         && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
   assign out_valid_o = (wr_ff != rd_ff);
   assign out_data_o = mem_ff[rd_ff[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge sys_clk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ff[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end

   fifo_no_overrun_a: assert property (@(posedge sys_clk_i)
      disable iff (!rst_b_i) !in_ready_o |-> !out_valid_o == 1'b0)
      else $error("fifo full while reporting empty");
endmodule : byte_fifo

// ===== src/tag_nvm_access.sv
// link command engine for the shared tag / fault log row array
// Notes on behaviour
// - opcode 0x61 erases whole shared array, log rows too
// - opcode 0x62 loads up to 7 buffer bytes
// - opcode 0x63 reads buffer bytes 0 to 6
// - opcode 0x64 commits buffer to row [7:4]
// - opcode 0x65 row read: write, restart, read
// - row read advances row after 7 bytes
// - stop ends a row read anywhere
// - programming mode entered by 0x04 and key
// - opcode 0x05 returns to user mode
// - tag and log instructions act per mode
// - log has volatile record and 16x7 store
// - recorder has priority; host disables it first
// - reconfiguration rejected while record write runs
// - opcode 0x71 erases entire fault log
// - opcode 0x73 reads volatile log record
// - 0x75 reads one record, 0x76 all
// - record writes come from the management link
// - key 0xAC stops recording, enables log reads
// - log reads ignored while recording enabled
package tag_nvm_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h3A;
   localparam logic [7:0] OP_PROG_ON = 8'h04;
   localparam logic [7:0] OP_PROG_OFF = 8'h05;
   localparam logic [7:0] OP_TAG_ERASE = 8'h61;
   localparam logic [7:0] OP_BUF_LOAD = 8'h62;
   localparam logic [7:0] OP_BUF_READ = 8'h63;
   localparam logic [7:0] OP_COMMIT = 8'h64;
   localparam logic [7:0] OP_ROW_READ = 8'h65;
   localparam logic [7:0] OP_LOG_ERASE = 8'h71;
   localparam logic [7:0] OP_VOL_READ = 8'h73;
   localparam logic [7:0] OP_REC_OFF = 8'h74;
   localparam logic [7:0] OP_REC_READ = 8'h75;
   localparam logic [7:0] OP_ALL_READ = 8'h76;
   localparam logic [7:0] KEY_HI = 8'hE5;
   localparam logic [7:0] KEY_LO = 8'h3D;
   localparam logic [7:0] REC_KEY = 8'hAC;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam int ROWS = 16;
   localparam int ROW_BYTES = 7;
   localparam int CELLS = ROWS * ROW_BYTES;
   localparam logic [2:0] LAST_BYTE = 3'h6;
   localparam logic [2:0] IDX_END = 3'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam int CLK_MHZ = 25;
   localparam int ERASE_TIME_US = 50;
   localparam int PROG_TIME_US = 20;
   localparam logic [11:0] ERASE_CYC = 12'(ERASE_TIME_US * CLK_MHZ);
   localparam logic [11:0] PROG_CYC = 12'(PROG_TIME_US * CLK_MHZ);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_WR = 3'h3,
      ST_RD = 3'h2,
      ST_WAIT = 3'h6
   } link_st_t;
   typedef enum logic [2:0] {
      SRC_NONE = 3'h0,
      SRC_BUF = 3'h1,
      SRC_ROW = 3'h3,
      SRC_VOL = 3'h2,
      SRC_STAT = 3'h6
   } rd_src_t;
endpackage : tag_nvm_pkg

`timescale 1ns/1ps
module tag_nvm_access (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic fault_mode_i,
   input wire logic rec_req_i,
   input wire logic [3:0] rec_row_i,
   input wire logic [55:0] rec_data_i,
   output logic prog_mode_o,
   output logic rec_enabled_o,
   output logic nvm_busy_o
);
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   tag_nvm_pkg::link_st_t st_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [7:0] tx_ff;
   logic rnw_ff;
   logic first_ff;
   logic nack_ff;
   logic ack_oe_ff;
   logic push_ff;
   logic [8:0] push_data_ff;
   logic load_ff;
   logic scl_hold_ff;
   logic f_valid;
   logic f_ready;
   logic f_in_ready;
   logic [8:0] f_data;
   logic [7:0] mem_ff [tag_nvm_pkg::CELLS];
   logic [7:0] buf_ff [tag_nvm_pkg::ROW_BYTES];
   logic [7:0] vol_ff [tag_nvm_pkg::ROW_BYTES];
   logic [7:0] cmd_ff;
   logic [2:0] idx_ff;
   logic prog_ff;
   logic key_hi_ff;
   logic req_ff;
   logic read_en_ff;
   logic rej_ff;
   logic rec_busy_ff;
   logic [11:0] busy_ff;
   tag_nvm_pkg::rd_src_t src_ff;
   logic [2:0] rd_idx_ff;
   logic [3:0] rd_row_ff;
   logic [7:0] rd_byte;
   logic rd_take;
   logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
   logic pop, instr, dbyte, tag_ok, log_ok, rec_start;
   logic do_tag_erase, do_log_erase, do_load, do_commit;
   logic [7:0] b;
   logic [6:0] row_base;

   // pins pass two flops; the third stage only serves edge detection
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
      end
      else
      begin
         scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      end
   end

   assign scl_s = scl_sync_ff[1];
   assign sda_s = sda_sync_ff[1];
   assign scl_rise = scl_s && !scl_sync_ff[2];
   assign scl_fall = !scl_s && scl_sync_ff[2];
   assign start_ev = scl_s && scl_sync_ff[2] && !sda_s && sda_sync_ff[2];
   assign stop_ev = scl_s && scl_sync_ff[2] && sda_s && !sda_sync_ff[2];
   assign b = f_data[7:0];
   assign rd_take = load_ff && !f_valid && busy_ff == '0;

   // link byte engine: bit 8 of each byte is the acknowledge slot
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_ff <= tag_nvm_pkg::ST_IDLE;
         bit_ff <= '0;
         sh_ff <= '0;
         tx_ff <= '0;
         rnw_ff <= 1'b0;
         first_ff <= 1'b0;
         nack_ff <= 1'b0;
         ack_oe_ff <= 1'b0;
         push_ff <= 1'b0;
         push_data_ff <= '0;
         load_ff <= 1'b0;
      end
      else
      begin
         if (push_ff && f_in_ready)
         begin
            push_ff <= 1'b0;
         end
         if (rd_take)
         begin
            load_ff <= 1'b0;
            tx_ff <= rd_byte;
            ack_oe_ff <= !rd_byte[7];
         end
         if (start_ev)
         begin
            st_ff <= tag_nvm_pkg::ST_ADDR;
            // all ones: the clock fall right after start wraps it to 0
            bit_ff <= '1;
            ack_oe_ff <= 1'b0;
            load_ff <= 1'b0;
         end
         else if (stop_ev)
         begin
            st_ff <= tag_nvm_pkg::ST_IDLE;
            ack_oe_ff <= 1'b0;
            load_ff <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (bit_ff < tag_nvm_pkg::BIT_ACK)
            begin
               sh_ff <= {sh_ff[6:0], sda_s};
            end
            else
            begin
               nack_ff <= sda_s;
            end
         end
         else if (scl_fall)
         begin
            unique case (st_ff)
               tag_nvm_pkg::ST_IDLE, tag_nvm_pkg::ST_WAIT:
               begin
                  ack_oe_ff <= 1'b0;
               end
               tag_nvm_pkg::ST_ADDR:
               begin
                  if (bit_ff == tag_nvm_pkg::BIT_LAST)
                  begin
                     bit_ff <= tag_nvm_pkg::BIT_ACK;
                     rnw_ff <= sh_ff[0];
                     ack_oe_ff <= sh_ff[7:1] == tag_nvm_pkg::DEV_ADDR;
                     if (sh_ff[7:1] != tag_nvm_pkg::DEV_ADDR)
                     begin
                        st_ff <= tag_nvm_pkg::ST_WAIT;
                     end
                  end
                  else if (bit_ff == tag_nvm_pkg::BIT_ACK)
                  begin
                     bit_ff <= '0;
                     ack_oe_ff <= 1'b0;
                     first_ff <= 1'b1;
                     load_ff <= rnw_ff;
                     st_ff <= rnw_ff ? tag_nvm_pkg::ST_RD
                                     : tag_nvm_pkg::ST_WR;
                  end
                  else
                  begin
                     bit_ff <= bit_ff + 4'h1;
                  end
               end
               tag_nvm_pkg::ST_WR:
               begin
                  if (bit_ff == tag_nvm_pkg::BIT_LAST)
                  begin
                     bit_ff <= tag_nvm_pkg::BIT_ACK;
                     ack_oe_ff <= 1'b1;
                     push_ff <= 1'b1;
                     push_data_ff <= {first_ff, sh_ff};
                     first_ff <= 1'b0;
                  end
                  else if (bit_ff == tag_nvm_pkg::BIT_ACK)
                  begin
                     bit_ff <= '0;
                     ack_oe_ff <= 1'b0;
                  end
                  else
                  begin
                     bit_ff <= bit_ff + 4'h1;
                  end
               end
               tag_nvm_pkg::ST_RD:
               begin
                  if (bit_ff == tag_nvm_pkg::BIT_LAST)
                  begin
                     bit_ff <= tag_nvm_pkg::BIT_ACK;
                     ack_oe_ff <= 1'b0;
                  end
                  // a nack from the host closes the read
                  else if (bit_ff == tag_nvm_pkg::BIT_ACK)
                  begin
                     bit_ff <= '0;
                     load_ff <= !nack_ff;
                     if (nack_ff)
                     begin
                        st_ff <= tag_nvm_pkg::ST_WAIT;
                     end
                  end
                  else
                  begin
                     bit_ff <= bit_ff + 4'h1;
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     ack_oe_ff <= !tx_ff[6];
                  end
               end
               default:
               begin
                  st_ff <= tag_nvm_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // clock stretching carries fifo back-pressure and read latency
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         scl_hold_ff <= 1'b0;
      end
      else
      begin
         scl_hold_ff <= (push_ff && !f_in_ready) || (load_ff && !rd_take);
      end
   end

   assign scl_o = 1'b0;
   assign scl_oe_o = scl_hold_ff;
   assign sda_o = 1'b0;
   assign sda_oe_o = ack_oe_ff;

   byte_fifo #(
      .WIDTH(9),
      .DEPTH(4)
   ) u_rx_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push_ff),
      .in_ready_o(f_in_ready),
      .in_data_i(push_data_ff),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data)
   );

   // each instruction set only acts in its own mode
   assign tag_ok = prog_ff && !fault_mode_i;
   assign log_ok = read_en_ff && fault_mode_i;
   // recorder wins the array over a pending command
   assign rec_start = rec_req_i && fault_mode_i && !req_ff && busy_ff == '0;
   assign f_ready = busy_ff == '0 && !rec_start;
   assign pop = f_valid && f_ready;
   assign instr = pop && f_data[8];
   assign dbyte = pop && !f_data[8];
   assign do_tag_erase = instr && b == tag_nvm_pkg::OP_TAG_ERASE && tag_ok;
   assign do_log_erase = instr && b == tag_nvm_pkg::OP_LOG_ERASE && log_ok
                         && prog_ff;
   assign do_load = dbyte && cmd_ff == tag_nvm_pkg::OP_BUF_LOAD && tag_ok
                    && idx_ff != tag_nvm_pkg::IDX_END;
   assign do_commit = dbyte && cmd_ff == tag_nvm_pkg::OP_COMMIT && tag_ok
                      && idx_ff == '0;
   assign row_base = 7'(b[7:4] * tag_nvm_pkg::ROW_BYTES);

   // array cells are nonvolatile: no reset
   always_ff @(posedge sys_clk_i)
   begin
      // erase covers every row at once
      if (do_tag_erase || do_log_erase)
      begin
         for (int i = 0; i < tag_nvm_pkg::CELLS; i++)
         begin
            mem_ff[i] <= tag_nvm_pkg::ERASED;
         end
      end
      // commit can only clear bits, so unerased rows merge
      else if (do_commit)
      begin
         for (int i = 0; i < tag_nvm_pkg::ROW_BYTES; i++)
         begin
            mem_ff[7'(row_base + 7'(i))] <=
               mem_ff[7'(row_base + 7'(i))] & buf_ff[i];
         end
      end
      // record writes come only from the management link
      else if (rec_start)
      begin
         for (int i = 0; i < tag_nvm_pkg::ROW_BYTES; i++)
         begin
            mem_ff[7'(rec_row_i * 4'(tag_nvm_pkg::ROW_BYTES) + 7'(i))] <=
               rec_data_i[8*i +: 8];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < tag_nvm_pkg::ROW_BYTES; i++)
         begin
            buf_ff[i] <= tag_nvm_pkg::ERASED;
            vol_ff[i] <= '0;
         end
      end
      else
      begin
         // loaded bytes start at byte 0
         if (do_load)
         begin
            buf_ff[idx_ff] <= b;
         end
         if (rec_start)
         begin
            for (int i = 0; i < tag_nvm_pkg::ROW_BYTES; i++)
            begin
               vol_ff[i] <= rec_data_i[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cmd_ff <= '0;
         idx_ff <= '0;
         busy_ff <= '0;
         rec_busy_ff <= 1'b0;
      end
      else
      begin
         if (instr)
         begin
            cmd_ff <= b;
            idx_ff <= '0;
         end
         else if (dbyte && idx_ff != tag_nvm_pkg::IDX_END)
         begin
            idx_ff <= idx_ff + 3'h1;
         end
         if (do_tag_erase || do_log_erase)
         begin
            busy_ff <= tag_nvm_pkg::ERASE_CYC;
         end
         else if (do_commit || rec_start)
         begin
            busy_ff <= tag_nvm_pkg::PROG_CYC;
         end
         else if (busy_ff != '0)
         begin
            busy_ff <= busy_ff - 12'h1;
         end
         if (rec_start)
         begin
            rec_busy_ff <= 1'b1;
         end
         else if (busy_ff == 12'h1)
         begin
            rec_busy_ff <= 1'b0;
         end
      end
   end

   // mode control: programming key and recorder key
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prog_ff <= 1'b0;
         key_hi_ff <= 1'b0;
         req_ff <= 1'b0;
         read_en_ff <= 1'b0;
         rej_ff <= 1'b0;
      end
      else
      begin
         // taint bytes queued during record
         // queued bytes only pop after the record ends, so the taint
         // lasts until the fifo drains; later bytes in it are refused too
         if (push_ff && f_in_ready && rec_busy_ff)
         begin
            rej_ff <= 1'b1;
         end
         else if (!f_valid)
         begin
            rej_ff <= 1'b0;
         end
         if (instr && b == tag_nvm_pkg::OP_PROG_OFF)
         begin
            prog_ff <= 1'b0;
         end
         if (dbyte && cmd_ff == tag_nvm_pkg::OP_PROG_ON)
         begin
            if (idx_ff == '0)
            begin
               key_hi_ff <= b == tag_nvm_pkg::KEY_HI;
            end
            // key accepted unless a record is writing
            else if (idx_ff == 3'h1 && key_hi_ff && !rec_busy_ff
                     && !rej_ff && b == tag_nvm_pkg::KEY_LO)
            begin
               prog_ff <= 1'b1;
            end
         end
         // right key requests reads, any other resumes logging
         if (dbyte && cmd_ff == tag_nvm_pkg::OP_REC_OFF && idx_ff == '0)
         begin
            req_ff <= b == tag_nvm_pkg::REC_KEY;
            read_en_ff <= 1'b0;
         end
         else if (req_ff && !rec_busy_ff)
         begin
            read_en_ff <= 1'b1;
         end
      end
   end

   // read pointer: source, byte and row
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         src_ff <= tag_nvm_pkg::SRC_NONE;
         rd_idx_ff <= '0;
         rd_row_ff <= '0;
      end
      else if (instr)
      begin
         rd_idx_ff <= '0;
         rd_row_ff <= '0;
         src_ff <= tag_nvm_pkg::SRC_NONE;
         if (b == tag_nvm_pkg::OP_BUF_READ && tag_ok)
         begin
            src_ff <= tag_nvm_pkg::SRC_BUF;
         end
         else if (b == tag_nvm_pkg::OP_VOL_READ && log_ok)
         begin
            src_ff <= tag_nvm_pkg::SRC_VOL;
         end
         else if (b == tag_nvm_pkg::OP_ALL_READ && log_ok)
         begin
            src_ff <= tag_nvm_pkg::SRC_ROW;
         end
         else if (b == tag_nvm_pkg::OP_REC_OFF)
         begin
            src_ff <= tag_nvm_pkg::SRC_STAT;
         end
      end
      // the address byte selects the starting row
      else if (dbyte && idx_ff == '0
               && ((cmd_ff == tag_nvm_pkg::OP_ROW_READ && tag_ok)
                   || (cmd_ff == tag_nvm_pkg::OP_REC_READ && log_ok)))
      begin
         src_ff <= tag_nvm_pkg::SRC_ROW;
         rd_row_ff <= b[7:4];
      end
      // row advances after its seventh byte
      else if (rd_take)
      begin
         if (src_ff == tag_nvm_pkg::SRC_ROW
             && rd_idx_ff == tag_nvm_pkg::LAST_BYTE)
         begin
            rd_idx_ff <= '0;
            rd_row_ff <= rd_row_ff + 4'h1;
         end
         else if (rd_idx_ff != tag_nvm_pkg::IDX_END)
         begin
            rd_idx_ff <= rd_idx_ff + 3'h1;
         end
      end
   end

   always_comb
   begin
      rd_byte = tag_nvm_pkg::ERASED;
      unique case (src_ff)
         tag_nvm_pkg::SRC_BUF:
            if (rd_idx_ff != tag_nvm_pkg::IDX_END) rd_byte = buf_ff[rd_idx_ff];
         tag_nvm_pkg::SRC_VOL:
            if (rd_idx_ff != tag_nvm_pkg::IDX_END) rd_byte = vol_ff[rd_idx_ff];
         tag_nvm_pkg::SRC_ROW:
            rd_byte = mem_ff[7'(rd_row_ff * 4'(tag_nvm_pkg::ROW_BYTES)
                                + 7'(rd_idx_ff))];
         tag_nvm_pkg::SRC_STAT:
            rd_byte = {req_ff, req_ff, !req_ff || read_en_ff,
                       !req_ff || read_en_ff, 4'h0};
         default:
            rd_byte = tag_nvm_pkg::ERASED;
      endcase
   end

   assign prog_mode_o = prog_ff;
   assign rec_enabled_o = fault_mode_i && !req_ff;
   assign nvm_busy_o = busy_ff != '0;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   erase_whole_array_a: assert property (do_tag_erase |=>
      mem_ff[0] == tag_nvm_pkg::ERASED && mem_ff[111] == tag_nvm_pkg::ERASED)
      else $error("array erase left cells programmed");
   buf_load_first_a: assert property (do_load && idx_ff == '0
      |=> buf_ff[0] == $past(b))
      else $error("buffer load missed byte 0");
   commit_gate_a: assert property (do_commit |-> tag_ok ##1 busy_ff
      == tag_nvm_pkg::PROG_CYC)
      else $error("commit did not start programming");
   row_advance_a: assert property (rd_take && src_ff ==
      tag_nvm_pkg::SRC_ROW && rd_idx_ff == tag_nvm_pkg::LAST_BYTE
      |=> rd_idx_ff == '0 && rd_row_ff == $past(rd_row_ff) + 4'h1)
      else $error("row read did not advance");
   stop_ends_read_a: assert property (stop_ev |=>
      st_ff == tag_nvm_pkg::ST_IDLE && !sda_oe_o)
      else $error("stop did not end transfer");
   prog_entry_a: assert property ($rose(prog_ff) |->
      $past(dbyte) && $past(b) == tag_nvm_pkg::KEY_LO && !$past(rec_busy_ff))
      else $error("programming mode entered without key");
   prog_exit_a: assert property (instr && b ==
      tag_nvm_pkg::OP_PROG_OFF |=> !prog_ff [*2])
      else $error("programming mode not left");
   log_read_gate_a: assert property (instr && !log_ok &&
      (b == tag_nvm_pkg::OP_ALL_READ || b == tag_nvm_pkg::OP_VOL_READ)
      |=> src_ff == tag_nvm_pkg::SRC_NONE)
      else $error("log read served while recording");
   rec_priority_a: assert property (rec_start |-> !pop ##1
      rec_busy_ff && vol_ff[0] == $past(rec_data_i[7:0]))
      else $error("recorder lost priority");
   prog_reject_a: assert property (dbyte && rej_ff
      && cmd_ff == tag_nvm_pkg::OP_PROG_ON |=> prog_ff == $past(prog_ff))
      else $error("key accepted during record write");

   erase_seen_c: cover property (do_tag_erase ##[1:300] do_load);
   row_wrap_c: cover property (rd_take && rd_row_ff == 4'hF
      && rd_idx_ff == tag_nvm_pkg::LAST_BYTE);
   stretch_c: cover property (push_ff && !f_in_ready);
   read_en_c: cover property ($rose(read_en_ff));
endmodule : tag_nvm_access

// ===== dv/link_host_model.sv
// link host model on the open-drain clock and data wires
`timescale 1ns/1ps
module link_host_model (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   initial scl_low_o = 1'b0;
   initial sda_low_o = 1'b0;
   task automatic half;
      repeat (4) @(negedge clk_i);
   endtask : half
   // stretching honoured, bounded so a stuck wire cannot hang us
   task automatic rise;
      int n;
      n = 0;
      scl_low_o = 1'b0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (scl_i !== 1'b1 && n < 3000);
      repeat (3) @(negedge clk_i);
   endtask : rise
   task automatic xbit(input logic b, output logic r);
      sda_low_o = ~b;
      half();
      rise();
      r = sda_i;
      scl_low_o = 1'b1;
   endtask : xbit
   task automatic start;
      sda_low_o = 1'b0;
      half();
      rise();
      sda_low_o = 1'b1;
      half();
      scl_low_o = 1'b1;
   endtask : start
   task automatic stop;
      sda_low_o = 1'b1;
      half();
      rise();
      sda_low_o = 1'b0;
      half();
   endtask : stop
   task automatic xbyte(input logic [7:0] b, input logic a,
      output logic [7:0] r, output logic ra);
      for (int i = 7; i >= 0; i--) xbit(b[i], r[i]);
      xbit(a, ra);
   endtask : xbyte
endmodule : link_host_model

// ===== dv/testbench.sv
// bench for the link command engine and its shared row array
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic fault_mode_i = 1'b0;
   logic rec_req_i = 1'b0;
   logic [3:0] rec_row_i = 4'h2;
   logic [55:0] rec_data_i = 56'h66554433221100;
   logic scl_oe, sda_oe, scl_low, sda_low, prog, rec_en, busy;
   wire scl = ~(scl_oe | scl_low);
   wire sda = ~(sda_oe | sda_low);
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] r[$];
   always #20 sys_clk_i = ~sys_clk_i;
   tag_nvm_access i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .fault_mode_i(fault_mode_i),
      .rec_req_i(rec_req_i), .rec_row_i(rec_row_i),
      .rec_data_i(rec_data_i), .prog_mode_o(prog),
      .rec_enabled_o(rec_en), .nvm_busy_o(busy));
   link_host_model i_host (.clk_i(sys_clk_i), .scl_i(scl), .sda_i(sda),
      .scl_low_o(scl_low), .sda_low_o(sda_low));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] q[$], input logic p = 1'b1);
      logic [7:0] x;
      logic a;
      i_host.start();
      i_host.xbyte({tag_nvm_pkg::DEV_ADDR, 1'b0}, 1'b1, x, a);
      chk(a, 1'b0);
      foreach (q[i])
      begin
         i_host.xbyte(q[i], 1'b1, x, a);
         chk(a, 1'b0);
      end
      if (p) i_host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] q[$], input int n);
      logic [7:0] x;
      logic a;
      r.delete();
      wr(q, 1'b0);
      i_host.start();
      i_host.xbyte({tag_nvm_pkg::DEV_ADDR, 1'b1}, 1'b1, x, a);
      for (int k = 0; k < n; k++)
      begin
         i_host.xbyte(8'hFF, k == n - 1, x, a);
         r.push_back(x);
      end
      i_host.stop();
   endtask : rd
   task automatic idle;
      repeat (2000) if (busy !== 1'b0) @(negedge sys_clk_i);
   endtask : idle
   task automatic t_tag;
      wr('{8'h62, 8'h55});
      wr('{8'h04, 8'hE5, 8'h3D});
      chk(prog, 1'b1);
      rd('{8'h63}, 1);
      chk(r[0], 8'hFF);
      wr('{8'h61});
      idle();
      wr('{8'h62, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
      rd('{8'h63}, 8);
      for (int i = 0; i < 8; i++)
         chk(r[i], i < 7 ? 8'hA0 + i : 8'hFF);
      wr('{8'h64, 8'hF0});
      idle();
      rd('{8'h65, 8'hF0}, 3);
      chk(r[2], 8'hA2);
      rd('{8'h65, 8'hF0}, 14);
      for (int i = 0; i < 7; i++) chk(r[i], 8'hA0 + i);
      for (int i = 7; i < 14; i++) chk(r[i], 8'hFF);
      wr('{8'h05});
      chk(prog, 1'b0);
   endtask : t_tag
   task automatic t_log;
      fault_mode_i = 1'b1;
      @(negedge sys_clk_i);
      chk(rec_en, 1'b1);
      rec_req_i = 1'b1;
      @(negedge sys_clk_i);
      rec_req_i = 1'b0;
      chk(busy, 1'b1);
      wr('{8'h04, 8'hE5, 8'h3D});
      rd('{8'h73}, 1);
      chk(r[0], 8'hFF);
      rd('{8'h63}, 1);
      chk(r[0], 8'hFF);
      idle();
      chk(prog, 1'b0);
      rd('{8'h74, 8'hAC}, 1);
      chk(r[0], 8'hF0);
      chk(rec_en, 1'b0);
      rd('{8'h73}, 7);
      for (int i = 0; i < 7; i++) chk(r[i], 8'h11 * i);
      rd('{8'h75, 8'h20}, 7);
      for (int i = 0; i < 7; i++) chk(r[i], 8'h11 * i);
      rd('{8'h76}, 21);
      for (int i = 0; i < 21; i++)
         chk(r[i], i < 14 ? 8'hFF : 8'h11 * (i - 14));
      wr('{8'h04, 8'hE5, 8'h3D});
      wr('{8'h71});
      idle();
      rd('{8'h75, 8'h20}, 1);
      chk(r[0], 8'hFF);
      wr('{8'h74, 8'h00});
      chk(rec_en, 1'b1);
   endtask : t_log
   task automatic report_and_stop;
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (10) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      t_tag();
      t_log();
      report_and_stop();
   end
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
endmodule : testbench
